// >>> rtl/snc_defines.svh
// Purpose: Register numbers, field positions and reset values of the
//          switch node configuration register bank.
// Assumes: Registers are addressed by an 8-bit register number.
// Notes:   Definitions only.
`ifndef SNC_DEFINES_SVH
`define SNC_DEFINES_SVH

`define SNC_REG_IDENT     8'h00
`define SNC_REG_DESCR     8'h01
`define SNC_REG_CONFIG    8'h04
`define SNC_REG_NODE_ID   8'h05
`define SNC_REG_PLL       8'h06
`define SNC_REG_SW_DIV    8'h07
`define SNC_REG_REF_DIV   8'h08
`define SNC_REG_JTAG_ID   8'h09
`define SNC_REG_USERCODE  8'h0A
`define SNC_REG_DIR_LO    8'h0C
`define SNC_REG_DIR_HI    8'h0D
`define SNC_REG_RSVD_A    8'h10
`define SNC_REG_RSVD_B    8'h11
`define SNC_REG_DBG_SRC   8'h1F

`define SNC_CFG_WLOCK_BIT   31
`define SNC_CFG_PLOCK_BIT   8
`define SNC_CFG_HDR_BIT     0
`define SNC_CFG_MASK        32'h80000101
`define SNC_PLL_NORST_BIT   31
`define SNC_PLL_NOWAIT_BIT  30
`define SNC_PLL_BYPASS_BIT  29
`define SNC_PLL_JTAGB_BIT   28
`define SNC_PLL_MASK        32'hF39FFF7F
`define SNC_DIV_MASK        32'h0000FFFF
`define SNC_RSVD_MASK       32'h00000003
`define SNC_DBG_MASK        32'h00000013
`define SNC_REF_DIV_RESET   16'h0003
`define SNC_PLL_RESET       32'h00000000
`define SNC_TILE_RST_CYC    4'h8

`endif

// >>> rtl/snc_pkg.sv
// Purpose: Types of the switch node configuration register bank.
// Assumes: Constants come from snc_defines.svh.
// Notes:   Holds the state machine encoding and the state struct.
`default_nettype none
package snc_pkg;
  typedef enum logic [1:0] {
    SNC_IDLE  = 2'b01,
    SNC_RESET = 2'b10
  } snc_state_e;

  typedef struct packed {
    snc_state_e  st;
    logic [3:0]  rst_cnt;
    logic [31:0] cfg;
    logic [15:0] node_id;
    logic [31:0] pll;
    logic [15:0] sw_div;
    logic [15:0] ref_div;
    logic [31:0] dir_lo;
    logic [31:0] dir_hi;
    logic [1:0]  rsvd_a;
    logic [1:0]  rsvd_b;
    logic [4:0]  dbg;
    logic [31:0] rdata;
    logic        rvalid;
    logic        tile_rst;
    logic        no_wait;
    logic [3:0]  route_dir;
    logic        route_local;
    logic [7:0]  boot_cap;
    logic        boot_done;
  } snc_state_s;
endpackage
`default_nettype wire

// >>> rtl/snc_regs.sv
// Purpose: Configuration and status register bank of a node packet switch.
// Assumes: Single clock mclk at 10 MHz; reset is asynchronous, active high.
// Notes:   Registers answer read and write transactions by register number.
`include "snc_defines.svh"
`default_nettype none
module snc_regs
  import snc_pkg::*;
#(
  parameter logic [7:0]  SW_REVISION  = 8'h01,
  parameter logic [7:0]  SW_VERSION   = 8'h01,
  parameter logic [7:0]  NUM_LINKS    = 8'h08,
  parameter logic [7:0]  SW_PROCS     = 8'h02,
  parameter logic [7:0]  DEV_PROCS    = 8'h02,
  // Identity values are arbitrary.
  parameter logic [31:0] JTAG_ID      = 32'h00000001,
  parameter logic [13:0] OTP_USERCODE = 14'h0000,
  parameter logic [17:0] METAL_ID     = 18'h00000
) (
  // Clock and reset.
  input  wire logic        mclk,
  input  wire logic        reset,
  // Boot control pins, sampled after reset.
  input  wire logic [7:0]  boot_control_pins,
  // Register transaction port.
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_num,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rvalid,
  // Global debug event sources.
  input  wire logic        dbg_tile0,
  input  wire logic        dbg_tile1,
  // Routing lookup.
  input  wire logic        route_req,
  input  wire logic [15:0] route_dest,
  output logic [3:0]       route_dir,
  output logic             route_local,
  // Controls to the clocking and reset logic, plus header mode and node identity.
  output logic             tile_reset,
  output logic             pll_no_wait,
  output logic             pll_bypass,
  output logic             boot_from_jtag,
  output logic [2:0]       pll_out_div,
  output logic [12:0]      pll_fb_mul,
  output logic [6:0]       pll_in_div,
  output logic [15:0]      switch_clk_div,
  output logic [15:0]      ref_clk_div,
  output logic             one_byte_headers,
  output logic [15:0]      node_identity
);

  // Index of the most significant set bit of a mismatch word.
  function automatic logic [3:0] top_bit(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  snc_state_s q_r;
  snc_state_s q_nxt;
  logic [7:0] boot_s1_r;
  logic [7:0] boot_s2_r;
  logic [1:0] dbg_s1_r;
  logic [1:0] dbg_s2_r;

  // The boot pin synchroniser keeps running through reset, so the level
  // captured at the first edge after release is the real pin level.
  always_ff @(posedge mclk) begin
    boot_s1_r <= boot_control_pins;
    boot_s2_r <= boot_s1_r;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dbg_s1_r  <= 2'h0;
      dbg_s2_r  <= 2'h0;
    end else begin
      dbg_s1_r  <= {dbg_tile1, dbg_tile0};
      dbg_s2_r  <= dbg_s1_r;
    end
  end

  logic        wr_ok;
  logic        pll_wr;
  logic [15:0] mism;
  logic [3:0]  dim;

  always_comb begin
    q_nxt = q_r;
    // The write lock covers the configuration register itself.
    wr_ok = cfg_wr && !q_r.cfg[`SNC_CFG_WLOCK_BIT];
    pll_wr = wr_ok && (cfg_num == `SNC_REG_PLL)
             && !q_r.cfg[`SNC_CFG_PLOCK_BIT];
    if (!q_r.boot_done) begin
      q_nxt.boot_cap  = boot_s2_r;
      q_nxt.boot_done = 1'b1;
    end
    // Writes; read-only numbers fall through unchanged.
    if (wr_ok) begin
      if (cfg_num == `SNC_REG_CONFIG) begin
        q_nxt.cfg = cfg_wdata & `SNC_CFG_MASK;
      end else if (cfg_num == `SNC_REG_NODE_ID) begin
        q_nxt.node_id = cfg_wdata[15:0];
      end else if (cfg_num == `SNC_REG_SW_DIV) begin
        q_nxt.sw_div = cfg_wdata[15:0];
      end else if (cfg_num == `SNC_REG_REF_DIV) begin
        q_nxt.ref_div = cfg_wdata[15:0];
      end else if (cfg_num == `SNC_REG_DIR_LO) begin
        q_nxt.dir_lo = cfg_wdata;
      end else if (cfg_num == `SNC_REG_DIR_HI) begin
        q_nxt.dir_hi = cfg_wdata;
      end else if (cfg_num == `SNC_REG_RSVD_A) begin
        q_nxt.rsvd_a = cfg_wdata[1:0];
      end else if (cfg_num == `SNC_REG_RSVD_B) begin
        q_nxt.rsvd_b = cfg_wdata[1:0];
      end else if (cfg_num == `SNC_REG_DBG_SRC) begin
        q_nxt.dbg = {cfg_wdata[4], 2'b00, cfg_wdata[1:0]};
      end
    end
    if (pll_wr) begin
      q_nxt.pll = cfg_wdata & `SNC_PLL_MASK;
    end
    // A new debug event replaces the recorded source and beats a write to bits 1:0; a written bit 4 is kept.
    if (dbg_s2_r != 2'h0) begin
      q_nxt.dbg = {q_nxt.dbg[4], 2'h0, dbg_s2_r};
    end
    q_nxt.no_wait = q_nxt.pll[`SNC_PLL_NOWAIT_BIT];
    // A PLL write during the reset pulse updates the fields only.
    case (q_r.st)
      SNC_IDLE: begin
        q_nxt.tile_rst = 1'b0;
        if (pll_wr && !cfg_wdata[`SNC_PLL_NORST_BIT]) begin
          q_nxt.st       = SNC_RESET;
          q_nxt.rst_cnt  = `SNC_TILE_RST_CYC;
          q_nxt.tile_rst = 1'b1;
        end
      end
      SNC_RESET: begin
        q_nxt.tile_rst = 1'b1;
        q_nxt.rst_cnt  = q_r.rst_cnt - 4'h1;
        if (q_r.rst_cnt == 4'h1) begin
          q_nxt.st       = SNC_IDLE;
          q_nxt.tile_rst = 1'b0;
        end
      end
      default: begin
        q_nxt.st = SNC_IDLE;
      end
    endcase
    // Routing by the most significant mismatching identity bit.
    mism = route_dest ^ q_r.node_id;
    dim  = top_bit(mism);
    if (route_req) begin
      q_nxt.route_local = (mism == 16'h0000);
      if (dim[3]) begin
        q_nxt.route_dir = q_r.dir_hi[{dim[2:0], 2'b00} +: 4];
      end else begin
        q_nxt.route_dir = q_r.dir_lo[{dim[2:0], 2'b00} +: 4];
      end
    end
    // Reads; unmapped numbers read zero.
    q_nxt.rvalid = cfg_rd;
    q_nxt.rdata  = 32'h00000000;
    if (cfg_rd) begin
      if (cfg_num == `SNC_REG_IDENT) begin
        q_nxt.rdata = {8'h00, q_r.boot_cap, SW_REVISION, SW_VERSION};
      end else if (cfg_num == `SNC_REG_DESCR) begin
        q_nxt.rdata = {8'h00, NUM_LINKS, SW_PROCS, DEV_PROCS};
      end else if (cfg_num == `SNC_REG_CONFIG) begin
        q_nxt.rdata = q_r.cfg;
      end else if (cfg_num == `SNC_REG_NODE_ID) begin
        q_nxt.rdata = {16'h0000, q_r.node_id};
      end else if (cfg_num == `SNC_REG_PLL) begin
        q_nxt.rdata = q_r.pll;
      end else if (cfg_num == `SNC_REG_SW_DIV) begin
        q_nxt.rdata = {16'h0000, q_r.sw_div};
      end else if (cfg_num == `SNC_REG_REF_DIV) begin
        q_nxt.rdata = {16'h0000, q_r.ref_div};
      end else if (cfg_num == `SNC_REG_JTAG_ID) begin
        q_nxt.rdata = JTAG_ID;
      end else if (cfg_num == `SNC_REG_USERCODE) begin
        q_nxt.rdata = {OTP_USERCODE, METAL_ID};
      end else if (cfg_num == `SNC_REG_DIR_LO) begin
        q_nxt.rdata = q_r.dir_lo;
      end else if (cfg_num == `SNC_REG_DIR_HI) begin
        q_nxt.rdata = q_r.dir_hi;
      end else if (cfg_num == `SNC_REG_RSVD_A) begin
        q_nxt.rdata = {30'h00000000, q_r.rsvd_a};
      end else if (cfg_num == `SNC_REG_RSVD_B) begin
        q_nxt.rdata = {30'h00000000, q_r.rsvd_b};
      end else if (cfg_num == `SNC_REG_DBG_SRC) begin
        q_nxt.rdata = {27'h0000000, q_r.dbg};
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q_r         <= '0;
      q_r.st      <= SNC_IDLE;
      q_r.ref_div <= `SNC_REF_DIV_RESET;
      q_r.pll     <= `SNC_PLL_RESET;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign cfg_rdata        = q_r.rdata;
  assign cfg_rvalid       = q_r.rvalid;
  assign route_dir        = q_r.route_dir;
  assign route_local      = q_r.route_local;
  assign tile_reset       = q_r.tile_rst;
  assign pll_no_wait      = q_r.no_wait;
  assign pll_bypass       = q_r.pll[`SNC_PLL_BYPASS_BIT];
  assign boot_from_jtag   = q_r.pll[`SNC_PLL_JTAGB_BIT];
  assign pll_out_div      = q_r.pll[25:23];
  assign pll_fb_mul       = q_r.pll[20:8];
  assign pll_in_div       = q_r.pll[6:0];
  assign switch_clk_div   = q_r.sw_div;
  assign ref_clk_div      = q_r.ref_div;
  assign one_byte_headers = q_r.cfg[`SNC_CFG_HDR_BIT];
  assign node_identity    = q_r.node_id;

  a_wlock_blocks: assert property (@(posedge mclk) disable iff (reset)
    (cfg_wr && q_r.cfg[31] && cfg_num == `SNC_REG_NODE_ID)
    |=> $stable(q_r.node_id))
    else $error("Node identifier changed while write locked.");
  a_plock_blocks: assert property (@(posedge mclk) disable iff (reset)
    (cfg_wr && q_r.cfg[8] && cfg_num == `SNC_REG_PLL) |=> $stable(q_r.pll))
    else $error("PLL settings changed while PLL locked.");
  a_hdr_mode: assert property (@(posedge mclk) disable iff (reset)
    (cfg_wr && !q_r.cfg[31] && cfg_num == `SNC_REG_CONFIG)
    |=> one_byte_headers == $past(cfg_wdata[0]))
    else $error("Header mode did not follow the write.");
  a_node_write: assert property (@(posedge mclk) disable iff (reset)
    (cfg_wr && !q_r.cfg[31] && cfg_num == `SNC_REG_NODE_ID)
    |=> node_identity == $past(cfg_wdata[15:0]))
    else $error("Node identifier write lost.");
  a_pll_reset: assert property (@(posedge mclk) disable iff (reset)
    (pll_wr && !cfg_wdata[31] && q_r.st == SNC_IDLE) |=> tile_reset [*8]
    ##1 !tile_reset)
    else $error("Tile reset pulse has the wrong length.");
  a_pll_norst: assert property (@(posedge mclk) disable iff (reset)
    (pll_wr && cfg_wdata[31] && q_r.st == SNC_IDLE) |=> !tile_reset)
    else $error("Tile reset despite suppression bit.");
  a_lock_norst: assert property (@(posedge mclk) disable iff (reset)
    (cfg_wr && cfg_num == `SNC_REG_PLL && q_r.cfg[8] && q_r.st == SNC_IDLE)
    |=> !tile_reset)
    else $error("Refused PLL write reset the tile.");
  a_route_local: assert property (@(posedge mclk) disable iff (reset)
    (route_req && route_dest == q_r.node_id) |=> route_local)
    else $error("Matching destination not flagged local.");
  a_usercode_rd: assert property (@(posedge mclk) disable iff (reset)
    (cfg_rd && cfg_num == `SNC_REG_USERCODE)
    |=> cfg_rvalid && cfg_rdata == {OTP_USERCODE, METAL_ID})
    else $error("User code read wrong.");
  a_dbg_src: assert property (@(posedge mclk) disable iff (reset)
    (dbg_s2_r == 2'h1) |=> q_r.dbg[1:0] == 2'h1)
    else $error("Debug source not recorded.");

  // Register port answers, read-only contents, write lock, PLL fields, dividers and routing.
  a_rd_answer: assert property (@(posedge mclk) disable iff (reset)
    cfg_rd |=> cfg_rvalid)
    else $error("Read strobe got no answer.");
  a_rd_quiet: assert property (@(posedge mclk) disable iff (reset)
    !cfg_rd |=> !cfg_rvalid && cfg_rdata == 32'h00000000)
    else $error("Read data shown without a read strobe.");
  a_ident_rd: assert property (@(posedge mclk) disable iff (reset)
    (cfg_rd && cfg_num == `SNC_REG_IDENT)
    |=> cfg_rdata[31:24] == 8'h00
        && cfg_rdata[15:0] == {SW_REVISION, SW_VERSION})
    else $error("Identification read wrong.");
  a_descr_rd: assert property (@(posedge mclk) disable iff (reset)
    (cfg_rd && cfg_num == `SNC_REG_DESCR)
    |=> cfg_rdata == {8'h00, NUM_LINKS, SW_PROCS, DEV_PROCS})
    else $error("Switch description read wrong.");
  a_wlock_all: assert property (@(posedge mclk) disable iff (reset)
    (cfg_wr && q_r.cfg[`SNC_CFG_WLOCK_BIT])
    |=> $stable(q_r.cfg) && $stable(q_r.pll) && $stable(q_r.sw_div)
        && $stable(q_r.dir_lo) && $stable(q_r.dir_hi))
    else $error("Register changed while write locked.");
  a_pll_flags: assert property (@(posedge mclk) disable iff (reset)
    pll_wr |=> pll_no_wait == $past(cfg_wdata[`SNC_PLL_NOWAIT_BIT])
    && pll_bypass == $past(cfg_wdata[`SNC_PLL_BYPASS_BIT])
    && boot_from_jtag == $past(cfg_wdata[`SNC_PLL_JTAGB_BIT]))
    else $error("PLL control flags did not follow the write.");
  a_pll_divs: assert property (@(posedge mclk) disable iff (reset)
    pll_wr |=> pll_out_div == $past(cfg_wdata[25:23])
    && pll_fb_mul == $past(cfg_wdata[20:8])
    && pll_in_div == $past(cfg_wdata[6:0]))
    else $error("PLL divider fields did not follow the write.");
  a_sw_div: assert property (@(posedge mclk) disable iff (reset)
    (wr_ok && cfg_num == `SNC_REG_SW_DIV)
    |=> switch_clk_div == $past(cfg_wdata[15:0]))
    else $error("Switch clock divider write lost.");
  a_ref_div: assert property (@(posedge mclk) disable iff (reset)
    (wr_ok && cfg_num == `SNC_REG_REF_DIV)
    |=> ref_clk_div == $past(cfg_wdata[15:0]))
    else $error("Reference clock divider write lost.");
  a_dir_high: assert property (@(posedge mclk) disable iff (reset)
    (route_req && mism[15]) |=> route_dir == $past(q_r.dir_hi[31:28]))
    else $error("Top dimension did not use the upper direction field.");
  a_dbg_rsvd: assert property (@(posedge mclk) disable iff (reset)
    (cfg_rd && cfg_num == `SNC_REG_DBG_SRC) |=> cfg_rdata[3:2] == 2'h0)
    else $error("Reserved debug source bits read non-zero.");

  c_pll_write: cover property (@(posedge mclk) disable iff (reset)
    pll_wr ##1 tile_reset);
  c_locked_wr: cover property (@(posedge mclk) disable iff (reset)
    cfg_wr && q_r.cfg[31]);
  c_route_hi: cover property (@(posedge mclk) disable iff (reset)
    route_req && mism[15]);
  c_norst_write: cover property (@(posedge mclk) disable iff (reset)
    pll_wr && cfg_wdata[`SNC_PLL_NORST_BIT]);
  c_dbg_tile1: cover property (@(posedge mclk) disable iff (reset)
    dbg_s2_r == 2'h2);

endmodule
`default_nettype wire

// >>> test/snc_regs_tb.sv
// Purpose: Self-checking bench for the switch node configuration bank.
// Assumes: Inputs change on the falling edge of a 10 MHz mclk.
// Notes:   Register traffic goes through the bank's own strobe protocol.
`include "snc_defines.svh"
`default_nettype none
module snc_regs_tb;
  import snc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [31:0] JID = 32'h0000ABC1;
  localparam logic [7:0]  BOOT = 8'hA5;
  localparam logic [7:0]  RWN [7] = '{`SNC_REG_NODE_ID, `SNC_REG_SW_DIV,
    `SNC_REG_REF_DIV, `SNC_REG_DIR_LO, `SNC_REG_DIR_HI, `SNC_REG_RSVD_A,
    `SNC_REG_RSVD_B};
  localparam logic [31:0] RWM [7] = '{32'h0000FFFF, 32'h0000FFFF,
    32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00000003, 32'h00000003};
  localparam logic [31:0] PLLV = 32'h72ABCD5A;

  logic        mclk;
  logic        reset;
  logic [7:0]  boot_control_pins;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [7:0]  cfg_num;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic        cfg_rvalid;
  logic        dbg_tile0;
  logic        dbg_tile1;
  logic        route_req;
  logic [15:0] route_dest;
  logic [3:0]  route_dir;
  logic        route_local;
  logic        tile_reset;
  logic        pll_no_wait;
  logic        pll_bypass;
  logic        boot_from_jtag;
  logic [2:0]  pll_out_div;
  logic [12:0] pll_fb_mul;
  logic [6:0]  pll_in_div;
  logic [15:0] switch_clk_div;
  logic [15:0] ref_clk_div;
  logic        one_byte_headers;
  logic [15:0] node_identity;
  int          err_count;
  int          comparisons;

  snc_regs #(.SW_REVISION(8'h12), .SW_VERSION(8'h34), .JTAG_ID(JID),
    .OTP_USERCODE(14'h2A5C), .METAL_ID(18'h3C3C3)) DUT (
    .mclk(mclk), .reset(reset), .boot_control_pins(boot_control_pins),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_num(cfg_num),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .dbg_tile0(dbg_tile0), .dbg_tile1(dbg_tile1), .route_req(route_req),
    .route_dest(route_dest), .route_dir(route_dir),
    .route_local(route_local), .tile_reset(tile_reset),
    .pll_no_wait(pll_no_wait), .pll_bypass(pll_bypass),
    .boot_from_jtag(boot_from_jtag), .pll_out_div(pll_out_div),
    .pll_fb_mul(pll_fb_mul), .pll_in_div(pll_in_div),
    .switch_clk_div(switch_clk_div), .ref_clk_div(ref_clk_div),
    .one_byte_headers(one_byte_headers), .node_identity(node_identity));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] n, input logic [31:0] d);
    @(negedge mclk);
    cfg_wr = 1'b1;
    cfg_num = n;
    cfg_wdata = d;
    @(negedge mclk);
    cfg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] n, input logic [31:0] e);
    @(negedge mclk);
    cfg_rd = 1'b1;
    cfg_num = n;
    @(negedge mclk);
    cfg_rd = 1'b0;
    chk({31'h0, cfg_rvalid}, 32'h1);
    chk(cfg_rdata, e);
  endtask

  task automatic route(input logic [15:0] d, input logic [3:0] e,
                       input logic l);
    @(negedge mclk);
    route_req = 1'b1;
    route_dest = d;
    @(negedge mclk);
    route_req = 1'b0;
    chk({27'h0, route_local, route_dir}, {27'h0, l, e});
  endtask

  task automatic stop_test();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    stop_test();
  end

  initial begin
    err_count = 0;
    comparisons = 0;
    reset = 1'b1;
    boot_control_pins = BOOT;
    {cfg_wr, cfg_rd, dbg_tile0, dbg_tile1, route_req} = 5'h00;
    cfg_num = 8'h00;
    cfg_wdata = 32'h00000000;
    route_dest = 16'h0000;
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    // Reset values, then all-ones and all-zeros through each of the seven RW registers in RWN.
    rd(`SNC_REG_CONFIG, 32'h0);
    for (int i = 0; i < 7; i++) begin
      rd(RWN[i], (i == 2) ? 32'h3 : 32'h0);
      wr(RWN[i], 32'hFFFFFFFF);
      rd(RWN[i], RWM[i]);
      wr(RWN[i], 32'h0);
      rd(RWN[i], 32'h0);
    end
    // Read-only registers refuse writes; unmapped numbers read zero.
    wr(`SNC_REG_IDENT, 32'hFFFFFFFF);
    wr(`SNC_REG_DESCR, 32'hFFFFFFFF);
    wr(`SNC_REG_USERCODE, 32'hFFFFFFFF);
    wr(8'h02, 32'hFFFFFFFF);
    rd(`SNC_REG_IDENT, {8'h00, BOOT, 8'h12, 8'h34});
    rd(`SNC_REG_DESCR, 32'h00080202);
    rd(`SNC_REG_JTAG_ID, JID);
    rd(`SNC_REG_USERCODE, {14'h2A5C, 18'h3C3C3});
    rd(8'h02, 32'h0);
    wr(`SNC_REG_CONFIG, 32'h7FFFFEFF);
    rd(`SNC_REG_CONFIG, 32'h00000001);
    chk({31'h0, one_byte_headers}, 32'h1);
    wr(`SNC_REG_SW_DIV, 32'h0000BEEF);
    wr(`SNC_REG_REF_DIV, 32'hFFFF1234);
    chk({switch_clk_div, ref_clk_div}, 32'hBEEF1234);
    // Routing by the most significant mismatching identifier bit.
    wr(`SNC_REG_NODE_ID, 32'h00001234);
    chk({16'h0, node_identity}, 32'h1234);
    wr(`SNC_REG_DIR_LO, 32'h76543210);
    wr(`SNC_REG_DIR_HI, 32'hFEDCBA98);
    route(16'h1234, 4'h0, 1'b1);
    for (int k = 0; k < 16; k++)
      route(16'h1234 ^ ((16'h1 << k) | ((16'h1 << k) - 16'h1)),
            4'(k), 1'b0);
    // Accepted PLL write: fields land and the tile reset lasts 8 cycles.
    wr(`SNC_REG_PLL, PLLV);
    for (int i = 0; i < 8; i++) begin
      chk({31'h0, tile_reset}, 32'h1);
      @(negedge mclk);
    end
    chk({31'h0, tile_reset}, 32'h0);
    chk({29'h0, pll_no_wait, pll_bypass, boot_from_jtag}, 32'h7);
    chk({pll_out_div, pll_fb_mul, pll_in_div}, {PLLV[25:23], PLLV[20:8],
        PLLV[6:0]});
    rd(`SNC_REG_PLL, PLLV & `SNC_PLL_MASK);
    // Bit 31 set skips the tile reset.
    wr(`SNC_REG_PLL, 32'h80000001);
    repeat (2) begin
      chk({31'h0, tile_reset}, 32'h0);
      @(negedge mclk);
    end
    rd(`SNC_REG_PLL, 32'h80000001);
    // PLL lock refuses the write and its tile reset.
    wr(`SNC_REG_CONFIG, 32'h00000100);
    wr(`SNC_REG_PLL, 32'h0000007F);
    repeat (2) begin
      chk({31'h0, tile_reset}, 32'h0);
      @(negedge mclk);
    end
    rd(`SNC_REG_PLL, 32'h80000001);
    // Debug source follows whichever tile raised the event.
    dbg_tile0 = 1'b1;
    repeat (4) @(negedge mclk);
    rd(`SNC_REG_DBG_SRC, 32'h1);
    dbg_tile0 = 1'b0;
    dbg_tile1 = 1'b1;
    repeat (4) @(negedge mclk);
    rd(`SNC_REG_DBG_SRC, 32'h2);
    dbg_tile1 = 1'b0;
    repeat (4) @(negedge mclk);
    wr(`SNC_REG_DBG_SRC, 32'hFFFFFFFF);
    rd(`SNC_REG_DBG_SRC, 32'h13);
    // Global write lock refuses every later write, itself included.
    wr(`SNC_REG_CONFIG, 32'h80000000);
    wr(`SNC_REG_NODE_ID, 32'h0000BEEF);
    wr(`SNC_REG_CONFIG, 32'h00000000);
    rd(`SNC_REG_NODE_ID, 32'h00001234);
    rd(`SNC_REG_CONFIG, 32'h80000000);
    stop_test();
  end
endmodule
`default_nettype wire
